// >>> rtl/xpc_program_control.sv
// programming and reset control of an 8x8 crosspoint
// How it works
// - reset low disables every output
// - reset clears only output enables
// - shift register has no assumed initial value
// - full serial load rewrites all outputs
// - released reset restores committed enables
// - each output selects any input freely
// - 32 bits: enable then select per output
// - data sampled on shift clock falling edge
// - commit low makes latches transparent
`timescale 1ns/1ps
`default_nettype none
module xpc_program_control #(
    parameter int NUM_OUT = xpc_pkg::NUM_OUT,
    parameter int SEL_W   = xpc_pkg::SEL_W
) (
    // clock and reset
    input  wire logic                     CLK_SYS,
    input  wire logic                     SYS_RST,

    // pin level reset, active low
    input  wire logic                     RESET_N,

    // serial programming pins
    input  wire logic                     DEV_SEL_N,
    input  wire logic                     SHIFT_CLK,
    input  wire logic                     SERIAL_DATA_IN,

    // matrix update strobe, active low
    input  wire logic                     COMMIT_N,

    // matrix state
    output logic [NUM_OUT*SEL_W-1:0]      SOURCE_SELECT,
    output logic [NUM_OUT-1:0]            OUTPUT_ENABLE,

    // shift register view and daisy chain
    output logic [NUM_OUT*(SEL_W+1)-1:0]  SHIFT_STATE,
    output logic                          SERIAL_DATA_OUT
);

    // field geometry follows the parameters
    localparam int FW     = SEL_W + 1;
    localparam int LB     = NUM_OUT * FW;
    localparam int EN_POS = SEL_W;

    // the serial format is fixed, so other geometries are refused
    if (NUM_OUT != xpc_pkg::NUM_OUT) begin : g_bad_outputs
        $error("crosspoint control serves exactly 8 outputs");
    end

    if (SEL_W != xpc_pkg::SEL_W) begin : g_bad_select
        $error("crosspoint control serves exactly 3 select bits");
    end

    if (LB != xpc_pkg::LOAD_BITS) begin : g_bad_length
        $error("serial load must be exactly 32 bits long");
    end

    if (EN_POS != xpc_pkg::FIELD_EN_POS) begin : g_bad_field
        $error("enable bit must sit just above the select bits");
    end

    // shift clock edge detector
    logic                      sclk_reg;
    logic                      sclk_next;
    logic                      shift_fall;
    logic                      shift_take;

    // shift register
    logic [LB-1:0]             shift_reg;
    logic [LB-1:0]             shift_next;

    // matrix latches
    logic [LB-1:0]             latch_reg;
    logic [LB-1:0]             latch_next;
    logic                      commit_open;

    // decoded latch fields
    wire  [NUM_OUT*SEL_W-1:0]  select_field;
    wire  [NUM_OUT-1:0]        enable_field;

    // shift clock sampling
    always_comb begin
        sclk_next = SHIFT_CLK;
    end

    // resets to the idle level, so no false edge follows reset
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            sclk_reg <= xpc_pkg::SCLK_IDLE;
        end else begin
            sclk_reg <= sclk_next;
        end
    end

    always_comb begin
        shift_fall = sclk_reg & ~SHIFT_CLK;
    end

    // a deselected device ignores the shift clock
    always_comb begin
        shift_take = shift_fall & ~DEV_SEL_N;
    end

    // shift register next value
    always_comb begin
        shift_next = shift_reg;
        // first bit ends in top field
        if (shift_take) begin
            shift_next = {shift_reg[LB-2:0], SERIAL_DATA_IN};
        end
    end

    // no reset: contents undefined until loaded
    always_ff @(posedge CLK_SYS) begin
        shift_reg <= shift_next;
    end

    // latches open while commit is low
    always_comb begin
        commit_open = ~COMMIT_N;
    end

    // latch next value
    always_comb begin
        latch_next = latch_reg;
        // whole word copied, no stale field
        if (commit_open) begin
            latch_next = shift_reg;
        end
    end

    // sampled transparency costs one clock of latency
    // latches keep their program through reset
    always_ff @(posedge CLK_SYS) begin
        latch_reg <= latch_next;
    end

    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        wire [FW-1:0] field;

        assign field                          = latch_reg[i*FW +: FW];
        assign select_field[i*SEL_W +: SEL_W] = field[SEL_W-1:0];
        assign enable_field[i]                = field[EN_POS];
    end

    // source bits pass unchanged; a disabled output ignores them
    always_comb begin
        SOURCE_SELECT = select_field;
    end

    // reset gates enables without a clock edge
    always_comb begin
        OUTPUT_ENABLE = enable_field & {NUM_OUT{RESET_N}};
    end

    // shift register view for the controller
    always_comb begin
        SHIFT_STATE = shift_reg;
    end

    // daisy chain: top bit leaves first
    always_comb begin
        SERIAL_DATA_OUT = shift_reg[LB-1];
    end
endmodule
`default_nettype wire

// >>> rtl/xpc_pkg.sv
// constants shared by the crosspoint programming control
package xpc_pkg;
    localparam int NUM_OUT        = 8;
    localparam int NUM_IN         = 8;
    localparam int SEL_W          = 3;
    localparam int FIELD_W        = SEL_W + 1;
    localparam int LOAD_BITS      = NUM_OUT * FIELD_W;
    localparam int FIELD_SEL_LSB  = 0;
    localparam int FIELD_EN_POS   = 3;
    localparam logic [7:0] OUT_EN_RESET = 8'h00;
    localparam logic       SCLK_IDLE    = 1'b1;
endpackage

// >>> dv/xpc_sva.sv
// checker of crosspoint programming pins
`timescale 1ns/1ps
`default_nettype none
module xpc_sva (input wire logic CLK_SYS, SYS_RST, RESET_N, COMMIT_N, SHIFT_CLK,
    input wire logic DEV_SEL_N, SERIAL_DATA_IN, SERIAL_DATA_OUT,
    input wire logic [23:0] SOURCE_SELECT,
    input wire logic [7:0] OUTPUT_ENABLE, input wire logic [31:0] SHIFT_STATE);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // shift register is unknown until 32 bits went in
    logic sclk_q = 1'b1;
    logic [5:0] n_shift = 6'h00;
    logic loaded;
    always_ff @(posedge CLK_SYS) begin
        sclk_q <= SHIFT_CLK;
        if (sclk_q && !SHIFT_CLK && !DEV_SEL_N && n_shift != 6'h20) n_shift <= n_shift + 6'h01;
    end
    assign loaded = (n_shift == 6'h20);
    a_shift_in: assert property ($past(SHIFT_CLK) && !SHIFT_CLK && !DEV_SEL_N |=>
        SHIFT_STATE[0] == $past(SERIAL_DATA_IN)) else $error("shift bit");
    a_shift_move: assert property (loaded && $past(SHIFT_CLK) && !SHIFT_CLK && !DEV_SEL_N |=>
        SHIFT_STATE[31:1] == $past(SHIFT_STATE[30:0])) else $error("shift move");
    a_hold_desel: assert property (loaded && DEV_SEL_N |=> $stable(SHIFT_STATE))
        else $error("shift moved while deselected");
    a_dout_top: assert property (loaded |-> SERIAL_DATA_OUT == SHIFT_STATE[31])
        else $error("chain out");
    a_src_commit: assert property (loaded && !COMMIT_N |=>
        SOURCE_SELECT[2:0] == $past(SHIFT_STATE[2:0])) else $error("commit source");
    a_reset_off: assert property (!RESET_N |-> !OUTPUT_ENABLE) else $error("on");
    a_commit_en: assert property (!COMMIT_N ##1 RESET_N |->
        OUTPUT_ENABLE[7] == $past(SHIFT_STATE[31])) else $error("commit");
    c_com: cover property (!COMMIT_N);
    c_rst: cover property ($fell(RESET_N));
    c_sh: cover property ($fell(SHIFT_CLK));
endmodule
bind xpc_program_control xpc_sva chk (.*);
`default_nettype wire

// >>> dv/xpc_ctrl.sv
// controller model
`timescale 1ns/1ps
`default_nettype none
module xpc_ctrl (input wire logic CLK_SYS,
    output logic DEV_SEL_N = 1, SHIFT_CLK = 1, SERIAL_DATA_IN = 0);
    // top field first, data released inverted
    task automatic load(logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(posedge CLK_SYS) {DEV_SEL_N, SHIFT_CLK, SERIAL_DATA_IN} <= {2'b01, w[i]};
            @(posedge CLK_SYS) SHIFT_CLK <= 0;
        end
        @(posedge CLK_SYS) {DEV_SEL_N, SHIFT_CLK, SERIAL_DATA_IN} <= {2'b11, ~w[0]};
    endtask
endmodule
`default_nettype wire

// >>> dv/xpc_program_control_tb.sv
// bench of the crosspoint control
`timescale 1ns/1ps
`default_nettype none
module xpc_program_control_tb;
    logic CLK_SYS = 0, SYS_RST = 1, RESET_N = 1, COMMIT_N = 1;
    logic DEV_SEL_N, SHIFT_CLK, SERIAL_DATA_IN, SERIAL_DATA_OUT;
    logic [23:0] SOURCE_SELECT; logic [7:0] OUTPUT_ENABLE; logic [31:0] SHIFT_STATE;
    int num_errors = 0, n_tests = 0;
    xpc_ctrl M (.*);
    xpc_program_control DUT (.*);
    initial forever #2 CLK_SYS = ~CLK_SYS;
    task automatic chk(string n, logic [31:0] v, x); n_tests++;
        if (v !== x) begin num_errors++; $display("MISMATCH %s exp %h seen %h", n, x, v); end
    endtask
    task automatic summarize; $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_load(logic [31:0] w, logic [7:0] x, logic [23:0] y); M.load(w);
        @(negedge CLK_SYS) chk("state", SHIFT_STATE, w); chk("dout", SERIAL_DATA_OUT, w[31]);
        @(posedge CLK_SYS) COMMIT_N <= 0; @(posedge CLK_SYS) COMMIT_N <= 1;
        @(negedge CLK_SYS) chk("en", OUTPUT_ENABLE, x); chk("src", SOURCE_SELECT, y);
    endtask
    // system reset mid-run leaves the programmed matrix alone
    task automatic t_sysrst; @(posedge CLK_SYS) SYS_RST <= 1; @(posedge CLK_SYS) SYS_RST <= 0;
        @(negedge CLK_SYS) chk("hold", OUTPUT_ENABLE, 8'h01); chk("kept2", SHIFT_STATE, 32'h8);
    endtask
    // reset disables all, so no tied output is active
    task automatic t_reset; @(posedge CLK_SYS) RESET_N <= 0;
        #1 chk("off", OUTPUT_ENABLE, 0); chk("kept", SHIFT_STATE, 32'hD5D5_5DDD);
        @(posedge CLK_SYS) RESET_N <= 1; @(negedge CLK_SYS) chk("back", OUTPUT_ENABLE, 8'hA7);
    endtask
    initial begin repeat (3) @(posedge CLK_SYS); SYS_RST <= 0;
        t_load(32'hD5D5_5DDD, 8'hA7, 24'hB6_DB6D); t_reset();
        // pairs: outputs 7,6 and 5,4 from inputs 1,0; outputs 3,2 from inputs 7,6
        t_load(32'h9898_FE00, 8'hFC, 24'h20_8F80);
        // triples: outputs 7..5 and 4..2 from inputs 5..3
        t_load(32'hDCBD_CB72, 8'hFC, 24'hB1_D8FA);
        t_load(32'h0000_0008, 8'h01, 0);
        t_sysrst(); t_load(32'hD5D5_5DDD, 8'hA7, 24'hB6_DB6D);
        summarize(); end
    // five loads of about 70 cycles each, with ample margin
    initial begin #4000 num_errors++; summarize(); end
endmodule
`default_nettype wire
